// ### brag_pkg.sv
package brag_pkg;

   // Register byte offsets on the APB slave
   localparam logic [7:0] BIT_REVERSE_CONFIG_OFS   = 8'h00;
   localparam logic [7:0] CIRCULAR_ADDR_CONTROL_OFS = 8'h04;
   localparam logic [7:0] MOD_START_OFS            = 8'h08;
   localparam logic [7:0] MOD_END_OFS              = 8'h0C;
   localparam logic [7:0] LAST_WRITE_EA_OFS        = 8'h10;
   localparam logic [7:0] LAST_READ_EA_OFS         = 8'h14;

   // Field positions
   localparam int REV_ENABLE_BIT   = 15;
   localparam int REV_MOD_MSB      = 14;
   localparam int MOD_ENABLE_BIT   = 15;
   localparam int REV_SEL_LSB      = 4;
   localparam int MOD_SEL_LSB      = 0;

   // Reset values
   localparam logic [15:0] BIT_REVERSE_CONFIG_RST    = 16'h0000;
   localparam logic [15:0] CIRCULAR_ADDR_CONTROL_RST = 16'h00FF;
   localparam logic [15:0] MOD_START_RST             = 16'h0000;
   localparam logic [15:0] MOD_END_RST               = 16'hFFFF;

   // Pointer select value that names the stack pointer
   localparam logic [3:0]  STACK_PTR_IDX  = 4'hF;
   localparam logic [15:0] BYTE_STEP      = 16'h0001;
   localparam logic [15:0] WORD_STEP      = 16'h0002;

   // Indirect addressing modes
   typedef enum logic [2:0] {
      MODE_IND      = 3'h0,
      MODE_POST_DEC = 3'h1,
      MODE_POST_INC = 3'h2,
      MODE_PRE_DEC  = 3'h3,
      MODE_PRE_INC  = 3'h4,
      MODE_REG_OFS  = 3'h5
   } brag_mode_type;

   // Address request from decode and register file
   typedef struct packed {
      logic          valid;
      logic          write;
      logic          byte_acc;
      brag_mode_type mode;
      logic [3:0]    reg_idx;
      logic [15:0]   ptr;
      logic [15:0]   offset;
   } brag_req_type;

   // Address result towards memory and pointer write-back
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] ea;
      logic        wb_en;
      logic [3:0]  wb_idx;
      logic [15:0] wb_val;
      logic        rev_used;
      logic        mod_used;
   } brag_res_type;

endpackage : brag_pkg

// ### brag_agu.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Modulo correction may be applied to the address from any pointer register.
// - Wrap tests use above-upper or below-lower, so overshoots still wrap.
// - A corrected address is written back only for pre- or post-modify modes.
// - Register-plus-offset addresses are corrected but the pointer is kept.
// - Bit-reversed addresses come only from the write generator, never reads.
// - Pointer and modifier are both bit-reversed and added; the sum is reversed back to normal order.
// - Reversal needs select not 15, enable set, and pre- or post-increment mode.
// - A 15-bit reverse modifier field is held, usually half the buffer size.
// - Reversal assumes words: modifier scaled to bytes, address bit 0 forced 0.
// - Byte writes or other modes with reversal enabled get normal addresses.
// - Under reversal the pointer gets the modifier added, not the mode step.
// - Reversal beats modulo in the write generator; reads keep modulo.
module brag_agu (
   input  wire logic                  SYS_CLK_I,
   input  wire logic                  ARST_N_I,
   input  wire logic                  PSEL_I,
   input  wire logic                  PENABLE_I,
   input  wire logic                  PWRITE_I,
   input  wire logic [7:0]            PADDR_I,
   input  wire logic [31:0]           PWDATA_I,
   output logic [31:0]                PRDATA_O,
   output logic                       PREADY_O,
   output logic                       PSLVERR_O,
   input  wire brag_pkg::brag_req_type AGU_REQ_I,
   output brag_pkg::brag_res_type     AGU_RES_O
);

   logic [15:0] rev_cfg_q;
   logic [15:0] circ_ctl_q;
   logic [15:0] mod_start_q;
   logic [15:0] mod_end_q;
   logic [15:0] last_wr_ea_q;
   logic [15:0] last_rd_ea_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   brag_pkg::brag_res_type res_q;
   brag_pkg::brag_res_type res_d;

   logic        apb_setup;
   logic        apb_write;
   logic        addr_hit;
   logic [15:0] rd_word;

   // Bit order swap of a 16-bit word
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15-i];
      end
      return r;
   endfunction : rev16

   // Circular wrap against the buffer bounds
   function automatic logic [15:0] mod_fix(input logic [15:0] a,
                                           input logic        dec,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] len;
      len = hi - lo + 16'h0001;
      if (!dec && (a > hi)) begin
         return a - len;
      end else if (dec && (a < lo)) begin
         return a + len;
      end
      return a;
   endfunction : mod_fix

   // APB phase decode
   assign apb_setup = PSEL_I && !PENABLE_I;
   assign apb_write = PSEL_I && PENABLE_I && pready_q && PWRITE_I;

   // Read mux and address hit
   always_comb begin
      addr_hit = 1'b1;
      rd_word  = 16'h0000;
      case (PADDR_I)
         brag_pkg::BIT_REVERSE_CONFIG_OFS:    rd_word = rev_cfg_q;
         brag_pkg::CIRCULAR_ADDR_CONTROL_OFS: rd_word = circ_ctl_q;
         brag_pkg::MOD_START_OFS:             rd_word = mod_start_q;
         brag_pkg::MOD_END_OFS:               rd_word = mod_end_q;
         brag_pkg::LAST_WRITE_EA_OFS:         rd_word = last_wr_ea_q;
         brag_pkg::LAST_READ_EA_OFS:          rd_word = last_rd_ea_q;
         default:                             addr_hit = 1'b0;
      endcase
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= apb_setup;
         pslverr_q <= apb_setup && !addr_hit;
         if (apb_setup && !PWRITE_I) begin
            prdata_q <= {16'h0000, rd_word};
         end
      end
   end

   // Software-writable configuration
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rev_cfg_q   <= brag_pkg::BIT_REVERSE_CONFIG_RST;
         circ_ctl_q  <= brag_pkg::CIRCULAR_ADDR_CONTROL_RST;
         mod_start_q <= brag_pkg::MOD_START_RST;
         mod_end_q   <= brag_pkg::MOD_END_RST;
      end else if (apb_write) begin
         case (PADDR_I)
            brag_pkg::BIT_REVERSE_CONFIG_OFS: begin
               rev_cfg_q <= PWDATA_I[15:0];
            end
            brag_pkg::CIRCULAR_ADDR_CONTROL_OFS: begin
               circ_ctl_q <= PWDATA_I[15:0];
            end
            brag_pkg::MOD_START_OFS: begin
               mod_start_q <= PWDATA_I[15:0];
            end
            brag_pkg::MOD_END_OFS: begin
               mod_end_q <= PWDATA_I[15:0];
            end
            default: begin
               rev_cfg_q <= rev_cfg_q;
            end
         endcase
      end
   end

   // Address generation for one request
   always_comb begin
      logic        inc_mode;
      logic        dec_mode;
      logic        pre_mode;
      logic        modify;
      logic        rev_on;
      logic        mod_on;
      logic [15:0] step;
      logic [15:0] xb;
      logic [15:0] ptr_w;
      logic [15:0] nxt;
      logic [15:0] ofs_ea;
      logic [3:0]  rev_sel;
      logic [3:0]  mod_sel;
      // Defaults so no local is left unassigned
      inc_mode = 1'b0;
      dec_mode = 1'b0;
      pre_mode = 1'b0;
      modify   = 1'b0;
      rev_on   = 1'b0;
      mod_on   = 1'b0;
      step     = 16'h0000;
      xb       = 16'h0000;
      ptr_w    = 16'h0000;
      nxt      = 16'h0000;
      ofs_ea   = 16'h0000;
      rev_sel  = 4'h0;
      mod_sel  = 4'h0;
      inc_mode = (AGU_REQ_I.mode == brag_pkg::MODE_PRE_INC) ||
                 (AGU_REQ_I.mode == brag_pkg::MODE_POST_INC);
      dec_mode = (AGU_REQ_I.mode == brag_pkg::MODE_PRE_DEC) ||
                 (AGU_REQ_I.mode == brag_pkg::MODE_POST_DEC);
      pre_mode = (AGU_REQ_I.mode == brag_pkg::MODE_PRE_INC) ||
                 (AGU_REQ_I.mode == brag_pkg::MODE_PRE_DEC);
      modify   = inc_mode || dec_mode;
      rev_sel  = circ_ctl_q[brag_pkg::REV_SEL_LSB +: 4];
      mod_sel  = circ_ctl_q[brag_pkg::MOD_SEL_LSB +: 4];
      // Reversal only for word writes via incrementing pointer
      rev_on   = AGU_REQ_I.write && !AGU_REQ_I.byte_acc && inc_mode &&
                 (rev_sel != brag_pkg::STACK_PTR_IDX) &&
                 rev_cfg_q[brag_pkg::REV_ENABLE_BIT] &&
                 (AGU_REQ_I.reg_idx == rev_sel);
      // Modulo on the selected pointer, off when reversal wins
      mod_on   = circ_ctl_q[brag_pkg::MOD_ENABLE_BIT] &&
                 (AGU_REQ_I.reg_idx == mod_sel) &&
                 (modify || AGU_REQ_I.mode == brag_pkg::MODE_REG_OFS) &&
                 !rev_on;
      step     = AGU_REQ_I.byte_acc ? brag_pkg::BYTE_STEP
                                    : brag_pkg::WORD_STEP;
      // Modifier scaled to bytes, then added with reversed carry
      xb       = {rev_cfg_q[brag_pkg::REV_MOD_MSB:0], 1'b0};
      ptr_w    = {AGU_REQ_I.ptr[15:1], 1'b0};
      if (rev_on) begin
         nxt = rev16(rev16(ptr_w) + rev16(xb));
         nxt[0] = 1'b0;
      end else if (inc_mode) begin
         nxt = AGU_REQ_I.ptr + step;
      end else if (dec_mode) begin
         nxt = AGU_REQ_I.ptr - step;
      end else begin
         nxt = AGU_REQ_I.ptr;
      end
      if (mod_on && modify) begin
         nxt = mod_fix(nxt, dec_mode, mod_start_q, mod_end_q);
      end
      ofs_ea = AGU_REQ_I.ptr + AGU_REQ_I.offset;
      if (mod_on && AGU_REQ_I.mode == brag_pkg::MODE_REG_OFS) begin
         ofs_ea = mod_fix(ofs_ea, AGU_REQ_I.offset[15],
                          mod_start_q, mod_end_q);
      end
      res_d          = '0;
      res_d.valid    = AGU_REQ_I.valid;
      res_d.write    = AGU_REQ_I.write;
      res_d.wb_idx   = AGU_REQ_I.reg_idx;
      res_d.wb_val   = nxt;
      res_d.wb_en    = AGU_REQ_I.valid && modify;
      res_d.rev_used = AGU_REQ_I.valid && rev_on;
      res_d.mod_used = AGU_REQ_I.valid && mod_on;
      if (AGU_REQ_I.mode == brag_pkg::MODE_REG_OFS) begin
         res_d.ea = ofs_ea;
      end else if (pre_mode) begin
         res_d.ea = nxt;
      end else if (rev_on) begin
         res_d.ea = ptr_w;
      end else begin
         res_d.ea = AGU_REQ_I.ptr;
      end
   end

   // Registered result towards memory and register file
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         res_q <= '0;
      end else begin
         res_q <= res_d;
      end
   end

   // Last effective addresses for software to inspect
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         last_wr_ea_q <= 16'h0000;
         last_rd_ea_q <= 16'h0000;
      end else if (res_d.valid) begin
         if (res_d.write) begin
            last_wr_ea_q <= res_d.ea;
         end else begin
            last_rd_ea_q <= res_d.ea;
         end
      end
   end

   assign PRDATA_O  = prdata_q;
   assign PREADY_O  = pready_q;
   assign PSLVERR_O = pslverr_q;
   assign AGU_RES_O = res_q;

   // Reversed addresses only for writes
   chk_rev_write_only: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.rev_used |-> res_q.write && $past(AGU_REQ_I.write))
      else $error("reversed address on a read");

   // Reversed addresses are word aligned
   chk_rev_lsb_clear: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.rev_used |-> !res_q.ea[0] && !res_q.wb_val[0])
      else $error("reversed address has bit 0 set");

   // Offset mode never writes the pointer back
   chk_ofs_no_wb: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      $past(AGU_REQ_I.valid && AGU_REQ_I.mode == brag_pkg::MODE_REG_OFS)
      |-> !res_q.wb_en)
      else $error("offset mode wrote the pointer");

   // Write-back only for modify modes
   chk_wb_modes: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.wb_en |-> $past(AGU_REQ_I.mode != brag_pkg::MODE_IND &&
                            AGU_REQ_I.mode != brag_pkg::MODE_REG_OFS))
      else $error("write-back without modify mode");

   // Stack select never reverses
   chk_rev_sel_stack: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.rev_used |->
      $past(circ_ctl_q[brag_pkg::REV_SEL_LSB +: 4]) != brag_pkg::STACK_PTR_IDX
      && $past(rev_cfg_q[brag_pkg::REV_ENABLE_BIT]))
      else $error("reversal with stack select or disabled");

   // Byte accesses fall back to normal addresses
   chk_rev_byte_off: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      $past(AGU_REQ_I.valid && AGU_REQ_I.byte_acc) |-> !res_q.rev_used)
      else $error("reversal on a byte access");

   // Reversal disables modulo in the write path
   chk_rev_over_mod: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.valid && res_q.rev_used |-> !res_q.mod_used)
      else $error("modulo applied with reversal");

   // Corrected write-back stays inside the buffer
   chk_mod_bounds: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.mod_used && res_q.wb_en && $stable(mod_start_q) &&
      $stable(mod_end_q) && $past(AGU_REQ_I.ptr) >= mod_start_q &&
      $past(AGU_REQ_I.ptr) <= mod_end_q
      |-> res_q.wb_val >= mod_start_q && res_q.wb_val <= mod_end_q)
      else $error("modulo write-back outside the buffer");

   // Pre-increment reversal uses the updated pointer as address
   chk_rev_pre_ea: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.rev_used && $past(AGU_REQ_I.mode == brag_pkg::MODE_PRE_INC)
      |-> res_q.ea == res_q.wb_val && res_q.wb_en)
      else $error("pre-increment reversed address mismatch");

   // Reads keep modulo while reversal is on
   chk_read_mod_kept: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      $past(AGU_REQ_I.valid && !AGU_REQ_I.write &&
            circ_ctl_q[brag_pkg::MOD_ENABLE_BIT] &&
            AGU_REQ_I.reg_idx == circ_ctl_q[brag_pkg::MOD_SEL_LSB +: 4] &&
            AGU_REQ_I.mode != brag_pkg::MODE_IND)
      |-> res_q.mod_used)
      else $error("modulo dropped on a read");

   // Reversal only for incrementing modes
   chk_rev_inc_mode: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.rev_used |-> $past(AGU_REQ_I.mode == brag_pkg::MODE_PRE_INC ||
                               AGU_REQ_I.mode == brag_pkg::MODE_POST_INC))
      else $error("reversal outside increment modes");

   // Post-increment reversal addresses the aligned old pointer
   chk_rev_post_ea: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      res_q.rev_used && $past(AGU_REQ_I.mode == brag_pkg::MODE_POST_INC)
      |-> res_q.ea == {$past(AGU_REQ_I.ptr[15:1]), 1'b0})
      else $error("post-increment reversed address mismatch");

   // APB answers in the first access cycle
   chk_apb_ready: assert property (
      @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
      else $error("APB ready timing wrong");

endmodule : brag_agu

`default_nettype wire

// ### brag_wreg_model.sv
`timescale 1ns/10ps
`default_nettype none

// Pointer register file standing in for decode on the request side
module brag_wreg_model (
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire brag_pkg::brag_req_type cmd_i,
   input  wire brag_pkg::brag_res_type res_i,
   input  wire logic                   load_i,
   input  wire logic [3:0]             load_idx_i,
   input  wire logic [15:0]            load_val_i,
   output brag_pkg::brag_req_type      req_o
);
   logic [15:0] w_q [16];

   // Preload and pointer write-back
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            w_q[i] <= 16'h0000;
         end
      end else if (load_i) begin
         w_q[load_idx_i] <= load_val_i;
      end else if (res_i.valid && res_i.wb_en) begin
         w_q[res_i.wb_idx] <= res_i.wb_val;
      end
   end

   // Pointer from the file; inverted while idle so it never looks held
   always_comb begin
      req_o = cmd_i;
      req_o.ptr = cmd_i.valid ? w_q[cmd_i.reg_idx] : ~w_q[cmd_i.reg_idx];
   end
endmodule : brag_wreg_model

`default_nettype wire

// ### bit_reversed_modulo_agu_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
   n_errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module bit_reversed_modulo_agu_tb;
   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h00000000;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   brag_pkg::brag_req_type cmd = '0;
   brag_pkg::brag_req_type req;
   brag_pkg::brag_res_type res;
   brag_pkg::brag_res_type ee;
   logic                   load = 1'b0;
   logic [3:0]             load_idx = 4'h0;
   logic [15:0]            load_val = 16'h0000;
   logic [15:0]            w_q [16];
   logic [15:0]            cfg_q, ctl_q, ms_q, me_q;
   logic [31:0]            lfsr = 32'h54996028;
   logic [32:0]            ae;
   logic [15:0]            lw = 16'h0000;
   logic [15:0]            lr = 16'h0000;
   int                     n_errors = 0;
   int                     comparisons = 0;
   logic [32:0]            apb_exp [$];
   brag_pkg::brag_res_type agu_exp [$];
   logic [15:0] ctl_t [4] = '{16'h8022, 16'h80F2, 16'h8032, 16'h0022};
   logic [15:0] cfg_t [4] = '{16'h8004, 16'h8004, 16'h8004, 16'h0008};

   // Clock
   always #25 clk = ~clk;

   brag_agu DUT (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .AGU_REQ_I(req), .AGU_RES_O(res));

   brag_wreg_model u_model (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd),
      .res_i(res), .load_i(load), .load_idx_i(load_idx),
      .load_val_i(load_val), .req_o(req));

   function automatic logic [15:0] brev(input logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         brev[i] = v[15 - i];
      end
   endfunction : brev

   // Next state of the stimulus shift register
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // Expected result worked out from pointer, mode and settings
   function automatic brag_pkg::brag_res_type ref_res(
      input brag_pkg::brag_req_type r);
      brag_pkg::brag_res_type e;
      logic [15:0]            nv, st, len;
      logic                   rv, dn, md, inc, post;
      inc = r.mode inside {brag_pkg::MODE_POST_INC, brag_pkg::MODE_PRE_INC};
      post = r.mode inside {brag_pkg::MODE_POST_INC, brag_pkg::MODE_POST_DEC};
      dn = r.mode inside {brag_pkg::MODE_POST_DEC, brag_pkg::MODE_PRE_DEC};
      st = r.byte_acc ? 16'h0001 : 16'h0002;
      rv = r.write && !r.byte_acc && inc && r.reg_idx == ctl_q[7:4] &&
           ctl_q[7:4] != 4'hF && cfg_q[15];
      nv = inc ? r.ptr + st : (dn ? r.ptr - st : r.ptr);
      if (r.mode == brag_pkg::MODE_REG_OFS) nv = r.ptr + r.offset;
      dn = dn || (r.mode == brag_pkg::MODE_REG_OFS && r.offset[15]);
      md = ctl_q[15] && r.reg_idx == ctl_q[3:0] && !rv &&
           r.mode != brag_pkg::MODE_IND;
      len = me_q - ms_q + 16'h0001;
      if (md && !dn && nv > me_q) nv = nv - len;
      if (md && dn && nv < ms_q) nv = nv + len;
      if (rv) nv = brev(brev(r.ptr & 16'hFFFE) +
                        brev({cfg_q[14:0], 1'b0})) & 16'hFFFE;
      e = '0;
      e.valid = 1'b1;
      e.write = r.write;
      e.wb_en = inc || dn && r.mode != brag_pkg::MODE_REG_OFS;
      e.wb_idx = r.reg_idx;
      e.wb_val = nv;
      e.rev_used = rv;
      e.mod_used = md;
      e.ea = post ? (rv ? r.ptr & 16'hFFFE : r.ptr) :
             (r.mode == brag_pkg::MODE_IND ? r.ptr : nv);
      return e;
   endfunction : ref_res

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input logic [32:0] e);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      apb_exp.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && a == 8'h00) cfg_q = d;
      if (w && a == 8'h04) ctl_q = d;
      if (w && a == 8'h08) ms_q = d;
      if (w && a == 8'h0C) me_q = d;
   endtask : apb

   task automatic load_ptr(input logic [3:0] i, input logic [15:0] v);
      @(posedge clk);
      load <= 1'b1;
      load_idx <= i;
      load_val <= v;
      w_q[i] = v;
      @(posedge clk);
      load <= 1'b0;
   endtask : load_ptr

   task automatic agu(input brag_pkg::brag_mode_type m, input logic w,
                      input logic b, input logic [3:0] i, input logic [15:0] o);
      brag_pkg::brag_req_type r;
      brag_pkg::brag_res_type x;
      r = '{valid: 1'b1, write: w, byte_acc: b, mode: m, reg_idx: i,
            ptr: w_q[i], offset: o};
      x = ref_res(r);
      agu_exp.push_back(x);
      if (x.wb_en) w_q[i] = x.wb_val;
      if (w) lw = x.ea;
      else lr = x.ea;
      @(posedge clk);
      cmd <= r;
      @(posedge clk);
      cmd.valid <= 1'b0;
   endtask : agu

   task final_report;
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // Monitor: oldest note against each answer
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         ae = apb_exp.pop_front();
         `CHK(pslverr, ae[32])
         if (!pwrite) `CHK(prdata, ae[31:0])
      end
      if (res.valid === 1'b1) begin
         ee = agu_exp.pop_front();
         `CHK(res.ea, ee.ea)
         `CHK(res.wb_en, ee.wb_en)
         if (ee.wb_en) `CHK({res.wb_idx, res.wb_val}, {ee.wb_idx, ee.wb_val})
         `CHK({res.write, res.rev_used}, {ee.write, ee.rev_used})
         `CHK(res.mod_used, ee.mod_used)
      end
   end

   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      final_report;
   end

   // Main sequence
   initial begin
      cfg_q = brag_pkg::BIT_REVERSE_CONFIG_RST;
      ctl_q = brag_pkg::CIRCULAR_ADDR_CONTROL_RST;
      ms_q = brag_pkg::MOD_START_RST;
      me_q = brag_pkg::MOD_END_RST;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 16'h0000, 33'h000000000);
      apb(1'b0, 8'h04, 16'h0000, 33'h0000000FF);
      apb(1'b0, 8'h08, 16'h0000, 33'h000000000);
      apb(1'b0, 8'h0C, 16'h0000, 33'h00000FFFF);
      apb(1'b0, 8'h18, 16'h0000, 33'h100000000);
      apb(1'b1, 8'h18, 16'h1234, 33'h100000000);
      apb(1'b1, 8'h08, 16'h1000, 33'h000000000);
      apb(1'b1, 8'h0C, 16'h101F, 33'h000000000);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 8'h04, ctl_t[k], 33'h000000000);
         apb(1'b1, 8'h00, cfg_t[k], 33'h000000000);
         apb(1'b0, 8'h00, 16'h0000, {17'h00000, cfg_t[k]});
         repeat (2) @(posedge clk);
         for (int i = 1; i < 5; i++) load_ptr(4'(i), 16'h1000);
         repeat (60) begin
            lfsr = lfsr_next(lfsr);
            agu(lfsr[21] ? (lfsr[22] ? brag_pkg::MODE_POST_INC :
                brag_pkg::MODE_PRE_INC) :
                brag_pkg::brag_mode_type'(3'(lfsr[7:0] % 8'h06)),
                lfsr[8], lfsr[9] & lfsr[10], {3'h1, lfsr[11]},
                {{11{lfsr[20]}}, lfsr[17:13]});
         end
      end
      repeat (4) @(posedge clk);
      apb(1'b1, 8'h10, 16'h5555, 33'h000000000);
      apb(1'b0, 8'h10, 16'h0000, {17'h00000, lw});
      apb(1'b0, 8'h14, 16'h0000, {17'h00000, lr});
      final_report;
   end
endmodule : bit_reversed_modulo_agu_tb

`default_nettype wire
